/* File: src/twi_port.sv */
// two-wire serial port: slave receiver/transmitter, master engine, registers
`timescale 1ns/1ps
module twi_port import twi_pkg::*; (
    input  wire logic       i_core_clk,
    input  wire logic       i_rstn,
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [1:0] i_pin_dir,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic      [7:0] o_rdata,
    output logic            o_scl_o,
    output logic            o_scl_oe,
    output logic            o_sda_o,
    output logic            o_sda_oe,
    output logic            o_irq
);
    typedef struct packed {
        logic       en;
        logic       ov;
        logic [3:0] mode;
        logic       gcall_en;
        logic       ack_status;
        logic       ack_value;
        logic       ack_seq;
        logic       rx_req;
        logic       stop_req;
        logic       rstart_req;
        logic       start_req;
        logic [7:0] adr;
        logic [7:0] buff;
        logic [7:0] txd;
        logic       buf_full;
        logic       rw;
        logic [2:0] irq_st;
        logic [2:0] irq_mk;
        logic [7:0] rdata;
        logic       scl_s1;
        logic       scl_s2;
        logic       scl_d;
        logic       sda_s1;
        logic       sda_s2;
        logic       sda_d;
        sl_t        sst;
        logic [3:0] sbit;
        logic [7:0] sr;
        logic       s_low;
        logic       ackd;
        ms_t        mst;
        logic [1:0] q;
        logic [3:0] bcnt;
        logic [7:0] brg;
        logic       m_scl;
        logic       m_sda;
        logic       scl_oe;
        logic       sda_oe;
        logic       irq;
    } st_t;

    st_t r;
    st_t n;

    function automatic logic is_slave(input logic [3:0] m);
        return m == M_SL7 || m == M_SL10 || m == M_SL7SP || m == M_SL10SP;
    endfunction

    function automatic logic is_master(input logic [3:0] m);
        return m == M_MST || m == M_FWM;
    endfunction

    logic scl_r;
    logic scl_f;
    logic sta;
    logic sto;
    logic sl_on;
    logic ms_on;
    logic m_idle;
    logic hit;

    always_comb begin
        n = r;
        n.rdata  = RST_BYTE;
        n.scl_s1 = i_scl;
        n.scl_s2 = r.scl_s1;
        n.scl_d  = r.scl_s2;
        n.sda_s1 = i_sda;
        n.sda_s2 = r.sda_s1;
        n.sda_d  = r.sda_s2;
        scl_r  = r.scl_s2 & ~r.scl_d;
        scl_f  = ~r.scl_s2 & r.scl_d;
        sta    = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
        sto    = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;
        sl_on  = r.en & is_slave(r.mode);
        ms_on  = r.en & is_master(r.mode);
        m_idle = r.mst == MS_IDLE;
        hit    = 1'b0;

        // software clears come first so hardware sets below win
        if (i_wr) begin
            case (i_addr)
                A_CTRL1: begin
                    n.en   = i_wdata[C1_EN];
                    n.ov   = i_wdata[C1_OV];
                    n.mode = i_wdata[3:0];
                end
                A_CTRL2: begin
                    n.gcall_en  = i_wdata[C2_GCALL];
                    n.ack_value = i_wdata[C2_ACKVAL];
                    if (m_idle) begin
                        {n.ack_seq, n.rx_req, n.stop_req} = i_wdata[4:2];
                        {n.rstart_req, n.start_req}       = i_wdata[1:0];
                    end
                end
                A_ADDR: n.adr = i_wdata;
                A_BUF: begin
                    if (m_idle) begin
                        n.buff = i_wdata;
                        n.sr   = i_wdata;
                        n.txd  = i_wdata;
                        if (ms_on) begin
                            n.mst  = MS_TX;
                            n.bcnt = 4'h0;
                            n.q    = 2'h0;
                            n.brg  = r.adr;
                        end
                    end
                end
                A_IRQ:  n.irq_st = r.irq_st & ~i_wdata[2:0];
                A_MASK: n.irq_mk = i_wdata[2:0];
                default: ;
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                A_CTRL1: n.rdata = {1'b0, r.ov, r.en, 1'b0, r.mode};
                A_CTRL2: n.rdata = {r.gcall_en, r.ack_status, r.ack_value, r.ack_seq,
                                    r.rx_req, r.stop_req, r.rstart_req, r.start_req};
                A_ADDR:  n.rdata = r.adr;
                A_BUF: begin
                    n.rdata = r.buff;
                    n.buf_full = 1'b0;
                end
                A_STAT:  n.rdata = {5'h00, ~m_idle, r.rw, r.buf_full};
                A_IRQ:   n.rdata = {5'h00, r.irq_st};
                A_MASK:  n.rdata = {5'h00, r.irq_mk};
                default: n.rdata = RST_BYTE;
            endcase
        end

        // slave engine
        if (!sl_on) begin
            n.sst   = S_IDLE;
            n.s_low = 1'b0;
        end else if (sta) begin
            n.sst   = S_ADDR;
            n.sbit  = 4'h0;
            n.s_low = 1'b0;
            if (r.mode[3]) n.irq_st[I_START] = 1'b1;
        end else if (sto) begin
            n.sst   = S_IDLE;
            n.s_low = 1'b0;
            if (r.mode[3]) n.irq_st[I_STOP] = 1'b1;
        end else begin
            case (r.sst)
                S_ADDR, S_RX: begin
                    if (scl_r) begin
                        n.sr   = {r.sr[6:0], r.sda_s2};
                        n.sbit = r.sbit + 4'h1;
                    end else if (scl_f && r.sbit == NBITS) begin
                        // 10-bit modes accept the header byte, later bytes are data
                        hit = r.sst == S_RX
                            || (r.mode[0] ? r.sr[7:3] == TEN_HDR : r.sr[7:1] == r.adr[7:1])
                            || (r.gcall_en && r.sr == RST_BYTE);
                        if (hit) begin
                            if (r.sst == S_ADDR) n.rw = r.sr[0];
                            // withhold ack on full or overflow
                            n.ackd = ~r.buf_full & ~r.ov;
                            if (r.buf_full) n.ov = 1'b1;
                            if (~r.buf_full & ~r.ov) begin
                                n.buff     = r.sr;
                                n.buf_full = 1'b1;
                                n.s_low = 1'b1;
                            end
                            n.sst = S_ACK;
                        end else begin
                            n.sst = S_WAIT;
                        end
                    end
                end
                S_ACK: begin
                    if (scl_f) begin
                        n.irq_st[I_BYTE] = 1'b1;
                        n.sbit  = 4'h0;
                        n.s_low = 1'b0;
                        if (!r.ackd) begin
                            // a refused write byte keeps the slave listening for the next
                            n.sst = r.rw ? S_WAIT : S_RX;
                        end else if (r.rw) begin
                            n.sr    = r.txd;
                            n.s_low = ~r.txd[7];
                            n.sst   = S_TX;
                        end else begin
                            n.sst = S_RX;
                        end
                    end
                end
                S_TX: begin
                    if (scl_r) n.sbit = r.sbit + 4'h1;
                    if (scl_f) begin
                        if (r.sbit == NBITS) begin
                            n.s_low = 1'b0;
                            n.sst   = S_TXACK;
                        end else begin
                            n.sr    = {r.sr[6:0], 1'b0};
                            n.s_low = ~r.sr[6];
                        end
                    end
                end
                S_TXACK: begin
                    // master nack ends the transfer
                    if (scl_r) begin
                        n.ackd = ~r.sda_s2;
                        n.sst  = r.sda_s2 ? S_WAIT : S_ACK;
                    end
                end
                S_IDLE, S_WAIT: n.s_low = 1'b0;
                default: n.sst = S_IDLE;
            endcase
        end

        // master engine
        if (!ms_on) begin
            n.mst   = MS_IDLE;
            n.m_scl = 1'b0;
            n.m_sda = 1'b0;
        end else if (m_idle) begin
            n.q   = 2'h0;
            n.brg = r.adr;
            n.bcnt = 4'h0;
            if (r.start_req) n.mst = MS_START;
            else if (r.rstart_req) n.mst = MS_RSTART;
            else if (r.stop_req) n.mst = MS_STOP;
            // receive one byte or send ack
            else if (r.rx_req) n.mst = MS_RX;
            else if (r.ack_seq) n.mst = MS_ACK;
        end else if (r.brg != RST_BYTE) begin
            n.brg = r.brg - 8'h01;
        end else begin
            // one quarter of the bus clock is adr+1 core cycles
            n.brg = r.adr;
            n.q   = r.q + 2'h1;
            case (r.mst)
                MS_START: begin
                    case (r.q)
                        2'h0: {n.m_scl, n.m_sda} = 2'b00;
                        2'h1: n.m_sda = 1'b1;
                        2'h2: ;
                        default: begin
                            n.m_scl = 1'b1;
                            n.start_req = 1'b0;
                        end
                    endcase
                end
                MS_RSTART: begin
                    case (r.q)
                        2'h0: {n.m_scl, n.m_sda} = 2'b10;
                        2'h1: n.m_scl = 1'b0;
                        2'h2: n.m_sda = 1'b1;
                        default: begin
                            n.m_scl = 1'b1;
                            n.rstart_req = 1'b0;
                        end
                    endcase
                end
                MS_STOP: begin
                    case (r.q)
                        2'h0: {n.m_scl, n.m_sda} = 2'b11;
                        2'h1: n.m_scl = 1'b0;
                        2'h2: n.m_sda = 1'b0;
                        default: n.stop_req = 1'b0;
                    endcase
                end
                MS_TX, MS_RX, MS_ACK: begin
                    case (r.q)
                        2'h0: begin
                            n.m_scl = 1'b1;
                            if (r.mst == MS_TX) n.m_sda = r.bcnt != NBITS && ~r.sr[7];
                            else if (r.mst == MS_ACK) n.m_sda = ~r.ack_value;
                            else n.m_sda = 1'b0;
                        end
                        2'h1: n.m_scl = 1'b0;
                        2'h2: begin
                            if (r.mst == MS_TX && r.bcnt == NBITS) n.ack_status = r.sda_s2;
                            if (r.mst == MS_RX) n.sr = {r.sr[6:0], r.sda_s2};
                        end
                        default: begin
                            n.m_scl = 1'b1;
                            n.bcnt  = r.bcnt + 4'h1;
                            if (r.mst == MS_TX) n.sr = {r.sr[6:0], 1'b0};
                            if (r.mst == MS_RX && r.bcnt == 4'h7) begin
                                if (r.buf_full) n.ov = 1'b1;
                                n.buff     = r.sr;
                                n.buf_full = 1'b1;
                                n.rx_req   = 1'b0;
                            end
                            if (r.mst == MS_ACK) n.ack_seq = 1'b0;
                        end
                    endcase
                end
                default: n.mst = MS_IDLE;
            endcase
            if (r.q == 2'h3 && (r.mst != MS_TX || r.bcnt == NBITS)
                && (r.mst != MS_RX || r.bcnt == 4'h7)) begin
                n.mst = MS_IDLE;
                n.irq_st[I_BYTE] = 1'b1;
            end
        end

        // open-drain only with pins set as inputs
        n.scl_oe = r.en & i_pin_dir[0] & n.m_scl;
        n.sda_oe = r.en & i_pin_dir[1] & (n.m_sda | n.s_low);
        n.irq    = |(n.irq_st & n.irq_mk);
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            r      <= '0;
            r.sst  <= S_IDLE;
            r.mst  <= MS_IDLE;
            r.scl_s1 <= 1'b1;
            r.scl_s2 <= 1'b1;
            r.scl_d  <= 1'b1;
            r.sda_s1 <= 1'b1;
            r.sda_s2 <= 1'b1;
            r.sda_d  <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // pins only ever pull low; the level is always zero
    assign o_scl_o  = 1'b0;
    assign o_sda_o  = 1'b0;
    assign o_scl_oe = r.scl_oe;
    assign o_sda_oe = r.sda_oe;
    assign o_rdata  = r.rdata;
    assign o_irq    = r.irq;
endmodule

/* File: src/twi_pkg.sv */
// constants, register map and state types of the two-wire serial port
// Operation
// - port stays inactive until software sets the port enable bit
// - four-bit mode field picks master, slave variants or firmware master
// - master clock is core clock over four times baud value plus one
// - enabled port drives clock and data open-drain when direction bits are inputs
// - slave transmitter overrides the data pin with its own output bits
// - any slave mode raises the port flag on an address match
// - start and stop slave modes also flag start and stop conditions
// - match and following bytes get an automatic ack and load the buffer
// - a buffer already full withholds the ack for that transfer
// - an overflow flag already set withholds the ack for that transfer
// - withheld ack leaves the buffer unchanged but still raises the flag
// - reading the buffer clears full; overflow stays until software clears it
// - request bits and buffer writes are ignored while the master is busy
// - acknowledge sequence sends the current ack value bit
// - port flag rises on the ninth falling clock edge of a matched address
package twi_pkg;
    localparam logic [2:0] A_CTRL1 = 3'h0;
    localparam logic [2:0] A_CTRL2 = 3'h1;
    localparam logic [2:0] A_ADDR  = 3'h2;
    localparam logic [2:0] A_BUF   = 3'h3;
    localparam logic [2:0] A_STAT  = 3'h4;
    localparam logic [2:0] A_IRQ   = 3'h5;
    localparam logic [2:0] A_MASK  = 3'h6;
    localparam int C1_OV   = 6;
    localparam int C1_EN   = 5;
    localparam int C2_GCALL  = 7;
    localparam int C2_ACKVAL = 5;
    localparam int I_BYTE  = 0;
    localparam int I_START = 1;
    localparam int I_STOP  = 2;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] M_SL7    = 4'h6;
    localparam logic [3:0] M_SL10   = 4'h7;
    localparam logic [3:0] M_MST    = 4'h8;
    localparam logic [3:0] M_FWM    = 4'hb;
    localparam logic [3:0] M_SL7SP  = 4'he;
    localparam logic [3:0] M_SL10SP = 4'hf;
    localparam logic [4:0] TEN_HDR  = 5'h1e;
    localparam logic [3:0] NBITS    = 4'h8;
    typedef enum logic [6:0] {
        S_IDLE = 7'h01, S_ADDR = 7'h02, S_RX = 7'h04, S_ACK = 7'h08,
        S_TX = 7'h10, S_TXACK = 7'h20, S_WAIT = 7'h40
    } sl_t;
    typedef enum logic [6:0] {
        MS_IDLE = 7'h01, MS_START = 7'h02, MS_RSTART = 7'h04, MS_STOP = 7'h08,
        MS_TX = 7'h10, MS_RX = 7'h20, MS_ACK = 7'h40
    } ms_t;
endpackage

/* File: sim/twi_port_props.sv */
// assertion checker for the two-wire serial port
`timescale 1ns/1ps
module twi_port_props import twi_pkg::*; (
    input wire logic       i_core_clk,
    input wire logic       i_rstn,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [1:0] i_pin_dir,
    input wire logic       i_scl,
    input wire logic       i_sda,
    input wire logic [7:0] o_rdata,
    input wire logic       o_scl_o,
    input wire logic       o_scl_oe,
    input wire logic       o_sda_o,
    input wire logic       o_sda_oe,
    input wire logic       o_irq
);
    logic       en_r;
    logic [3:0] mode_r;
    logic [2:0] mask_r;
    logic       slv;
    assign slv = en_r && (mode_r inside {M_SL7, M_SL10, M_SL7SP, M_SL10SP});
    // shadow of the mode and mask fields, seen from the write port
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            en_r <= 1'b0;
            mode_r <= 4'h0;
            mask_r <= 3'h0;
        end else if (i_wr && i_addr == A_CTRL1) begin
            en_r <= i_wdata[C1_EN];
            mode_r <= i_wdata[3:0];
        end else if (i_wr && i_addr == A_MASK) begin
            mask_r <= i_wdata[2:0];
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    a_pins_open_drain: assert property (o_scl_o == 1'b0 && o_sda_o == 1'b0)
        else $error("pin output level not low");
    a_scl_dir_gate: assert property (o_scl_oe |-> $past(i_pin_dir[0]))
        else $error("clock pin driven while direction is output");
    a_sda_dir_gate: assert property (o_sda_oe |-> $past(i_pin_dir[1]))
        else $error("data pin driven while direction is output");
    a_off_pins_quiet: assert property (!en_r && $past(!en_r) |-> !o_scl_oe && !o_sda_oe)
        else $error("disabled port drives a pin");
    a_slave_no_clock: assert property (slv && $past(slv) |-> !o_scl_oe)
        else $error("slave mode drives the clock line");
    // slave data may only move while the clock line is low
    a_ack_scl_low: assert property (slv && $changed(o_sda_oe) |-> !i_scl)
        else $error("slave data changed with clock high");
    a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside the read slot");
    a_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) == 3'h7 |-> o_rdata == 8'h00)
        else $error("unmapped index read nonzero");
    a_irq_masked: assert property (mask_r == 3'h0 && $past(mask_r) == 3'h0 |-> !o_irq)
        else $error("interrupt raised with all masked");
    c_slave_ack: cover property (slv && $rose(o_sda_oe));
    c_master_clk: cover property (!slv && en_r && $rose(o_scl_oe));
    c_irq_rise: cover property ($rose(o_irq));
endmodule
bind twi_port twi_port_props twi_port_props_inst (.*);

/* File: sim/twi_peer.sv */
// bus peer: two-wire master model pulling clock and data open-drain
`timescale 1ns/1ps
module twi_peer (
    input  wire logic i_core_clk,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_scl_pull,
    output logic      o_sda_pull
);
    // phase length in core cycles; well above the slave's input sync delay
    localparam int Q = 6;
    initial begin
        o_scl_pull = 1'b0;
        o_sda_pull = 1'b0;
    end
    task automatic hold();
        repeat (Q) @(posedge i_core_clk);
    endtask
    task automatic start();
        o_sda_pull <= 1'b1;
        hold();
        o_scl_pull <= 1'b1;
        hold();
    endtask
    task automatic stop();
        o_sda_pull <= 1'b1;
        hold();
        o_scl_pull <= 1'b0;
        hold();
        o_sda_pull <= 1'b0;
        hold();
    endtask
    task automatic bit_cyc(input logic b, output logic s);
        o_sda_pull <= !b;
        hold();
        o_scl_pull <= 1'b0;
        hold();
        s = i_sda;
        o_scl_pull <= 1'b1;
        hold();
    endtask
    // eight data bits msb first, then the ninth bit; a = slave acknowledged
    task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r,
                        output logic a);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(d[i], s);
            r[i] = s;
        end
        bit_cyc(mack, s);
        a = !s;
    endtask
endmodule

/* File: sim/tb.sv */
// self-checking bench for the two-wire serial port
`timescale 1ns/1ps
module tb;
    import twi_pkg::*;
    logic       i_core_clk, i_rstn, i_wr, i_rd, ack, seen, sda_q, scl_q;
    logic [2:0] i_addr;
    logic [7:0] i_wdata, o_rdata, v;
    logic       o_scl_o, o_scl_oe, o_sda_o, o_sda_oe, o_irq, scl_pull, sda_pull;
    logic       scl, sda;
    logic [1:0] pin_dir;
    int         fail_count, total_checks, cyc, t0, gap;
    // wired-and bus with pull-ups
    assign scl = !(o_scl_oe || scl_pull);
    assign sda = !(o_sda_oe || sda_pull);
    twi_port twi_port_inst (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_pin_dir(pin_dir), .i_scl(scl),
        .i_sda(sda), .o_rdata(o_rdata), .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe),
        .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_irq(o_irq));
    twi_peer twi_peer_inst (.i_core_clk(i_core_clk), .i_scl(scl), .i_sda(sda),
        .o_scl_pull(scl_pull), .o_sda_pull(sda_pull));
    always #2 i_core_clk = !i_core_clk;
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // cycle count, hang limit and start-to-clock gap monitor
    always @(posedge i_core_clk) begin
        cyc++;
        if (o_sda_oe && !sda_q) t0 = cyc;
        if (o_scl_oe && !scl_q) gap = cyc - t0;
        sda_q = o_sda_oe;
        scl_q = o_scl_oe;
        if (cyc == 40000) begin
            fail_count++;
            results();
        end
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rc(input logic [2:0] a, input logic [7:0] e, input string n);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
        chk(n, e, v);
    endtask
    task automatic xf(input logic [7:0] d);
        twi_peer_inst.xfer(d, 1'b1, v, ack);
    endtask
    // wait for completion under a bound, noting whether data was pulled low
    task automatic done();
        seen = 1'b0;
        for (int i = 0; i < 2000 && o_irq !== 1'b1; i++) begin
            @(posedge i_core_clk);
            // data level only counts while the clock line is released
            if (o_sda_oe && !o_scl_oe) seen = 1'b1;
        end
        chk("irq_done", 8'h01, {7'h0, o_irq});
        wr(A_IRQ, 8'h07);
    endtask
    initial begin
        {i_core_clk, i_rstn, i_wr, i_rd, i_addr, i_wdata, sda_q, scl_q} = '0;
        pin_dir = 2'b11;
        repeat (8) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        wr(3'h7, 8'hff);
        rc(3'h7, 8'h00, "unmapped");
        rc(A_CTRL2, 8'h00, "ctrl2_reset");
        wr(A_MASK, 8'h07);
        wr(A_ADDR, 8'ha0);
        wr(A_CTRL1, 8'h06);
        twi_peer_inst.start();
        xf(8'ha0);
        chk("ack_disabled", 8'h00, {7'h0, ack});
        twi_peer_inst.stop();
        rc(A_IRQ, 8'h00, "irq_disabled");
        wr(A_CTRL1, 8'h26);
        pin_dir <= 2'b00;
        twi_peer_inst.start();
        xf(8'ha0);
        chk("ack_dir_out", 8'h00, {7'h0, ack});
        twi_peer_inst.stop();
        pin_dir <= 2'b11;
        rc(A_BUF, 8'ha0, "buf_dir_out");
        wr(A_IRQ, 8'h07);
        twi_peer_inst.start();
        xf(8'ha0);
        chk("ack_match", 8'h01, {7'h0, ack});
        rc(A_IRQ, 8'h01, "irq_match");
        chk("irq_pin", 8'h01, {7'h0, o_irq});
        wr(A_MASK, 8'h00);
        repeat (3) @(posedge i_core_clk);
        chk("irq_masked", 8'h00, {7'h0, o_irq});
        wr(A_MASK, 8'h07);
        rc(A_STAT, 8'h01, "stat_full");
        wr(A_IRQ, 8'h07);
        xf(8'h5a);
        chk("ack_full", 8'h00, {7'h0, ack});
        rc(A_IRQ, 8'h01, "irq_nack");
        rc(A_CTRL1, 8'h66, "overflow_set");
        rc(A_BUF, 8'ha0, "buf_kept");
        rc(A_STAT, 8'h00, "full_cleared");
        xf(8'h33);
        chk("ack_ovf", 8'h00, {7'h0, ack});
        rc(A_BUF, 8'ha0, "buf_kept_ovf");
        wr(A_CTRL1, 8'h26);
        xf(8'h44);
        chk("ack_data", 8'h01, {7'h0, ack});
        rc(A_BUF, 8'h44, "buf_data");
        twi_peer_inst.stop();
        wr(A_IRQ, 8'h07);
        wr(A_CTRL1, 8'h2e);
        twi_peer_inst.start();
        rc(A_IRQ, 8'h02, "irq_start");
        xf(8'ha0);
        twi_peer_inst.stop();
        rc(A_IRQ, 8'h07, "irq_stop");
        rc(A_BUF, 8'ha0, "buf_addr");
        wr(A_CTRL1, 8'h26);
        for (int g = 0; g < 2; g++) begin
            wr(A_CTRL2, g ? 8'h80 : 8'h00);
            twi_peer_inst.start();
            xf(8'h00);
            chk("gen_call", g[7:0], {7'h0, ack});
            twi_peer_inst.stop();
            rc(A_BUF, g ? 8'h00 : 8'ha0, "gen_call_buf");
        end
        wr(A_CTRL1, 8'h27);
        twi_peer_inst.start();
        xf(8'hf0);
        chk("ten_bit_hdr", 8'h01, {7'h0, ack});
        twi_peer_inst.stop();
        rc(A_BUF, 8'hf0, "ten_bit_buf");
        wr(A_CTRL1, 8'h26);
        wr(A_BUF, 8'hc3);
        twi_peer_inst.start();
        xf(8'ha1);
        xf(8'hff);
        chk("slave_tx", 8'hc3, v);
        twi_peer_inst.stop();
        wr(A_CTRL2, 8'h00);
        wr(A_IRQ, 8'h07);
        wr(A_ADDR, 8'h02);
        wr(A_CTRL1, 8'h28);
        wr(A_CTRL2, 8'h01);
        wr(A_CTRL2, 8'h04);
        done();
        chk("start_gap", 8'd6, gap[7:0]);
        rc(A_CTRL2, 8'h00, "req_cleared");
        wr(A_BUF, 8'h96);
        done();
        rc(A_CTRL2, 8'h40, "ack_status");
        wr(A_CTRL2, 8'h08);
        done();
        rc(A_BUF, 8'hff, "master_rx");
        wr(A_CTRL2, 8'h10);
        done();
        chk("ack_low", 8'h01, {7'h0, seen});
        wr(A_CTRL2, 8'h30);
        done();
        chk("nack_free", 8'h00, {7'h0, seen});
        wr(A_CTRL2, 8'h24);
        done();
        chk("stop_low", 8'h01, {7'h0, seen});
        wr(A_CTRL1, 8'h2b);
        wr(A_CTRL2, 8'h02);
        done();
        chk("rstart_low", 8'h01, {7'h0, seen});
        rc(A_CTRL2, 8'h40, "rstart_cleared");
        results();
    end
endmodule
